/* File: src/cvc_capstan_ctrl.sv */
// capstan velocity and position-hold control logic
// Contract
// - six sequential phase pulses from oscillator and gray counter time everything
// - pulse 83 ns at 2 MHz fast; 167 ns at 1 MHz slow
// - B leading A means forward; A leading B means backward
// - period counter counts phase one from tach pulse, stops at decode, signals match
// - position hold start times a 12 ms hitch reference interval
// - free-running long reference counter issues a 768 ms count pulse
// - after match, drive counter counts phase one from preset; loaded at next tach
// - in position hold drive counter tracks quarter tach pulses, sent continuously
// - gap counter is an eight-stage binary counter
// - threading steps the gap counter on reel revolutions
// - read and write step gap counter on quarter tach pulses
// - go-extension held after move drops until gap limit reached
// - high density limits: write 49, read 42, backward 16
// - low density limits: write 90, read 122, backward 90
// - stop completes 36 quarter tach pulses after go-extension drops
// - hold register captures drive count per full or quarter tach transition
// - deceleration compares period count with table nominal for match
// - deceleration drive counts from preset to next full transition, then loads
// - deceleration table addressed by gap counter value
// - gap counter decode supplies first and second stop delays near end of stop
// - power-on reset blocks motor drive current
// - DAC path 7 lines fast, 6 lines slow
`timescale 1ns/1ps
`default_nettype none
module cvc_capstan_ctrl #(
    parameter bit FAST = 1'b1,
    parameter int unsigned DAC_W = FAST ? cvc_pkg::DAC_W_FAST : cvc_pkg::DAC_W_SLOW,
    parameter int unsigned HOLD_REF_T1 = FAST ? cvc_pkg::HOLD_REF_T1_FAST
        : cvc_pkg::HOLD_REF_T1_SLOW,
    parameter int unsigned LONG_REF_T1 = FAST ? cvc_pkg::LONG_REF_T1_FAST
        : cvc_pkg::LONG_REF_T1_SLOW,
    parameter int unsigned RUN_PERIOD_T1 = 16
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic por_active,
    input wire cvc_pkg::cvc_tags_t tags,
    input wire logic tach_a,
    input wire logic tach_b,
    input wire logic reel_rev,
    output logic go_ext,
    output logic forward,
    output logic period_match,
    output logic hold_ref_done,
    output logic long_ref_pulse,
    output logic stop_delay1,
    output logic stop_delay2,
    output logic at_rest,
    output logic drive_enable,
    output logic [DAC_W-1:0] dac_cmd
);
    localparam int unsigned DW = DAC_W;

    cvc_pkg::cvc_phase_t phases;

    cvc_phase_gen #(.FAST(FAST)) u_phase (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .phases(phases)
    );

    typedef struct packed {
        logic [1:0] a_sync;
        logic [1:0] b_sync;
        logic [1:0] r_sync;
        logic a_d;
        logic b_d;
        logic r_d;
        logic [5:0] ph_d;
        cvc_pkg::cvc_mode_t mode;
        logic move_d;
        logic [cvc_pkg::TPC_W-1:0] tach_period_counter;
        logic tpc_run;
        logic [cvc_pkg::TPC_W-1:0] hold_cnt;
        logic hold_timing;
        logic [cvc_pkg::TPC_W-1:0] long_cnt;
        logic [7:0] proportional_drive_counter;
        logic pdc_run;
        logic [7:0] gap_counter;
        logic [7:0] polarity_hold_register;
        logic go_ext;
        logic forward;
        logic period_match;
        logic hold_ref_done;
        logic long_ref_pulse;
        logic stop_delay1;
        logic stop_delay2;
        logic at_rest;
        logic drive_enable;
        logic [DW-1:0] dac_cmd;
    } cvc_state_t;

    cvc_state_t st_r, st_nxt;

    // nominal decel tach periods in phase-one counts, indexed by gap count
    function automatic logic [9:0] decel_period_rom(input logic [5:0] idx);
        decel_period_rom = 10'(RUN_PERIOD_T1) + {idx, 3'h0};
    endfunction : decel_period_rom

    logic a_s, b_s, r_s;
    logic a_edge, b_edge, quarter, full, fwd_dir;
    logic t1, t2, t3, t4;
    logic [7:0] gap_limit;
    logic [7:0] stop_off;
    logic [cvc_pkg::TPC_W-1:0] target;

    assign a_s = st_r.a_sync[1];
    assign b_s = st_r.b_sync[1];
    assign r_s = st_r.r_sync[1];
    // phases stand several cycles; strobe the first so each pulse counts once
    assign t1 = phases.pulse[1] & ~st_r.ph_d[1];
    assign t2 = phases.pulse[2] & ~st_r.ph_d[2];
    assign t3 = phases.pulse[3] & ~st_r.ph_d[3];
    assign t4 = phases.pulse[4] & ~st_r.ph_d[4];

    always_comb begin
        a_edge = a_s ^ st_r.a_d;
        b_edge = b_s ^ st_r.b_d;
        quarter = a_edge | b_edge;
        full = a_edge & a_s;
        // on an A edge, B already equal to new A means B led
        fwd_dir = a_edge ? (b_s == a_s) : (b_edge ? (a_s != b_s) : st_r.forward);
        case ({tags.high_density, tags.write_op, tags.backward})
            3'b110: gap_limit = cvc_pkg::GAP_HI_WRITE;
            3'b100: gap_limit = cvc_pkg::GAP_HI_READ;
            3'b101: gap_limit = cvc_pkg::GAP_HI_BACK;
            3'b010: gap_limit = cvc_pkg::GAP_LO_WRITE;
            3'b011: gap_limit = cvc_pkg::GAP_LO_WRITE;
            3'b001: gap_limit = cvc_pkg::GAP_LO_BACK;
            3'b111: gap_limit = cvc_pkg::GAP_HI_WRITE;
            default: gap_limit = cvc_pkg::GAP_LO_READ;
        endcase
        stop_off = st_r.gap_counter;
        if (st_r.mode == cvc_pkg::CVC_STOP) begin
            target = cvc_pkg::TPC_W'(decel_period_rom(st_r.gap_counter[5:0]));
        end else begin
            target = cvc_pkg::TPC_W'(RUN_PERIOD_T1);
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.a_sync = {st_r.a_sync[0], tach_a};
        st_nxt.b_sync = {st_r.b_sync[0], tach_b};
        st_nxt.r_sync = {st_r.r_sync[0], reel_rev};
        st_nxt.a_d = a_s;
        st_nxt.b_d = b_s;
        st_nxt.r_d = r_s;
        st_nxt.ph_d = phases.pulse;
        st_nxt.move_d = tags.move;
        st_nxt.forward = fwd_dir;
        st_nxt.period_match = 1'b0;
        st_nxt.long_ref_pulse = 1'b0;
        st_nxt.hold_ref_done = 1'b0;

        // period counter: restart on full tach, count phase one to decode
        if (full) begin
            st_nxt.tach_period_counter = '0;
            st_nxt.tpc_run = 1'b1;
        end else if (st_r.tpc_run && t1) begin
            if (st_r.tach_period_counter + 1'b1 == target) begin
                st_nxt.tpc_run = 1'b0;
                st_nxt.period_match = 1'b1;
            end
            st_nxt.tach_period_counter = st_r.tach_period_counter + 1'b1;
        end

        // free-running long reference
        if (t1) begin
            if (st_r.long_cnt == cvc_pkg::TPC_W'(LONG_REF_T1 - 1)) begin
                st_nxt.long_cnt = '0;
                st_nxt.long_ref_pulse = 1'b1;
            end else begin
                st_nxt.long_cnt = st_r.long_cnt + 1'b1;
            end
        end

        // hitch reference from start of hold
        if (st_r.hold_timing && t1) begin
            if (st_r.hold_cnt == cvc_pkg::TPC_W'(HOLD_REF_T1 - 1)) begin
                st_nxt.hold_timing = 1'b0;
                st_nxt.hold_ref_done = 1'b1;
            end else begin
                st_nxt.hold_cnt = st_r.hold_cnt + 1'b1;
            end
        end

        // gap counter stepping
        if (tags.thread) begin
            if (r_s && !st_r.r_d) begin
                st_nxt.gap_counter = st_r.gap_counter + 8'h01;
            end
        end else if (quarter && st_r.mode != cvc_pkg::CVC_IDLE) begin
            st_nxt.gap_counter = st_r.gap_counter + 8'h01;
        end

        // velocity loop: drive counter counts phase one after match
        if (st_r.period_match) begin
            st_nxt.pdc_run = 1'b1;
        end
        if (st_r.mode != cvc_pkg::CVC_IDLE && st_r.pdc_run && t1) begin
            st_nxt.proportional_drive_counter = st_r.proportional_drive_counter + 8'h01;
        end
        if (st_r.mode != cvc_pkg::CVC_IDLE && full) begin
            // slow tach means larger count, more current
            st_nxt.polarity_hold_register = st_r.proportional_drive_counter;
            st_nxt.proportional_drive_counter = cvc_pkg::DRV_RUN_PRESET;
            st_nxt.pdc_run = 1'b0;
        end

        case (st_r.mode)
            cvc_pkg::CVC_IDLE: begin
                // position hold: count quarter steps, signed by direction
                if (quarter) begin
                    st_nxt.proportional_drive_counter = fwd_dir
                        ? st_r.proportional_drive_counter - 8'h01
                        : st_r.proportional_drive_counter + 8'h01;
                    st_nxt.polarity_hold_register = st_nxt.proportional_drive_counter;
                end
                if (tags.move) begin
                    st_nxt.mode = cvc_pkg::CVC_START;
                    st_nxt.go_ext = 1'b1;
                    st_nxt.at_rest = 1'b0;
                    st_nxt.hold_timing = 1'b0;
                end
            end
            cvc_pkg::CVC_START: begin
                if (t3) begin
                    st_nxt.proportional_drive_counter = cvc_pkg::DRV_START_PRESET;
                end
                if (t4) begin
                    st_nxt.polarity_hold_register = cvc_pkg::DRV_START_PRESET;
                    st_nxt.mode = cvc_pkg::CVC_RUN;
                end
            end
            cvc_pkg::CVC_RUN: begin
                if (!tags.move && st_r.move_d) begin
                    st_nxt.gap_counter = 8'h00;
                    st_nxt.mode = cvc_pkg::CVC_EXT;
                end
            end
            cvc_pkg::CVC_EXT: begin
                if (tags.move) begin
                    st_nxt.mode = cvc_pkg::CVC_RUN;
                end else if (st_r.gap_counter >= gap_limit) begin
                    st_nxt.go_ext = 1'b0;
                    st_nxt.gap_counter = 8'h00;
                    st_nxt.mode = cvc_pkg::CVC_STOP;
                end
            end
            cvc_pkg::CVC_STOP: begin
                // last two quarter steps of the stop
                st_nxt.stop_delay1 = stop_off == cvc_pkg::GAP_STOP_DIST - 8'h02;
                st_nxt.stop_delay2 = stop_off == cvc_pkg::GAP_STOP_DIST - 8'h01;
                if (st_r.gap_counter >= cvc_pkg::GAP_STOP_DIST) begin
                    st_nxt.mode = cvc_pkg::CVC_IDLE;
                    st_nxt.at_rest = 1'b1;
                    st_nxt.stop_delay1 = 1'b0;
                    st_nxt.stop_delay2 = 1'b0;
                    st_nxt.proportional_drive_counter = 8'h00;
                    st_nxt.polarity_hold_register = 8'h00;
                    st_nxt.hold_cnt = '0;
                    st_nxt.hold_timing = 1'b1;
                end
            end
            default: st_nxt.mode = cvc_pkg::CVC_IDLE;
        endcase

        st_nxt.drive_enable = !por_active;
        if (t2 || st_r.mode == cvc_pkg::CVC_IDLE) begin
            st_nxt.dac_cmd = por_active ? '0
                : st_nxt.polarity_hold_register[7 -: DW];
        end
        if (por_active) begin
            st_nxt.dac_cmd = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.mode <= cvc_pkg::CVC_IDLE;
            st_r.at_rest <= 1'b1;
            st_r.forward <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign go_ext = st_r.go_ext;
    assign forward = st_r.forward;
    assign period_match = st_r.period_match;
    assign hold_ref_done = st_r.hold_ref_done;
    assign long_ref_pulse = st_r.long_ref_pulse;
    assign stop_delay1 = st_r.stop_delay1;
    assign stop_delay2 = st_r.stop_delay2;
    assign at_rest = st_r.at_rest;
    assign drive_enable = st_r.drive_enable;
    assign dac_cmd = st_r.dac_cmd;

    a_por_blocks_dac: assert property (@(posedge sys_clk) disable iff (!resetn)
        por_active |=> dac_cmd == '0 && !drive_enable) else $error("drive not blocked");
    a_reset_clears: assert property (@(posedge sys_clk)
        !resetn |=> dac_cmd == '0 && st_r.gap_counter == 8'h00) else $error("reset left state");
    a_match_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
        period_match |=> !period_match) else $error("match not one cycle");
    a_match_target: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(period_match) |-> st_r.tach_period_counter == $past(target))
        else $error("match at wrong count");
    a_ext_limit: assert property (@(posedge sys_clk) disable iff (!resetn)
        $fell(go_ext) |-> $past(st_r.gap_counter) >= $past(gap_limit))
        else $error("go-extension dropped early");
    a_ext_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        st_r.mode == cvc_pkg::CVC_EXT && st_r.gap_counter < gap_limit |=> go_ext)
        else $error("go-extension dropped before limit");
    a_stop_dist: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(at_rest) |-> $past(st_r.gap_counter) >= cvc_pkg::GAP_STOP_DIST)
        else $error("stop too short");
    a_hold_capture: assert property (@(posedge sys_clk) disable iff (!resetn)
        st_r.mode == cvc_pkg::CVC_RUN && full |=>
        st_r.polarity_hold_register == $past(st_r.proportional_drive_counter))
        else $error("hold register missed capture");
    a_gap_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        st_r.mode == cvc_pkg::CVC_STOP && quarter && !tags.thread
        && st_r.gap_counter < cvc_pkg::GAP_STOP_DIST |=>
        st_r.gap_counter == $past(st_r.gap_counter) + 8'h01) else $error("gap not stepped");
    a_long_period: assert property (@(posedge sys_clk) disable iff (!resetn)
        long_ref_pulse |=> !long_ref_pulse) else $error("long pulse too wide");
    a_thread_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        tags.thread && r_s && !st_r.r_d && st_r.mode == cvc_pkg::CVC_IDLE |=>
        st_r.gap_counter == $past(st_r.gap_counter) + 8'h01) else $error("reel step lost");

    c_start: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(go_ext));
    c_ext_drop: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(go_ext));
    c_rest: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(at_rest));
    c_match: cover property (@(posedge sys_clk) disable iff (!resetn) period_match);
endmodule : cvc_capstan_ctrl
`default_nettype wire

/* File: inc/cvc_pkg.sv */
// constants and carrier types for the capstan velocity control block
package cvc_pkg;
    localparam int unsigned SYS_CLK_MHZ = 100;
    // phase pulse timing, faster and slower variants
    localparam int unsigned PH_WIDTH_FAST_NS = 83;
    localparam int unsigned PH_WIDTH_SLOW_NS = 167;
    localparam int unsigned PH_RATE_FAST_MHZ = 2;
    localparam int unsigned PH_RATE_SLOW_MHZ = 1;
    // longest time rounds down, at least one cycle
    localparam int unsigned PH_CYC_FAST = (PH_WIDTH_FAST_NS * SYS_CLK_MHZ) / 1000;
    localparam int unsigned PH_CYC_SLOW = (PH_WIDTH_SLOW_NS * SYS_CLK_MHZ) / 1000;
    localparam int unsigned PH_FAST = (PH_CYC_FAST < 1) ? 1 : PH_CYC_FAST;
    localparam int unsigned PH_SLOW = (PH_CYC_SLOW < 1) ? 1 : PH_CYC_SLOW;
    localparam int unsigned PH_COUNT = 6;
    // reference intervals in ms, as counts of phase-one pulses
    localparam int unsigned HOLD_REF_MS = 12;
    localparam int unsigned LONG_REF_MS = 768;
    localparam int unsigned HOLD_REF_T1_FAST = HOLD_REF_MS * 1000 * PH_RATE_FAST_MHZ;
    localparam int unsigned HOLD_REF_T1_SLOW = HOLD_REF_MS * 1000 * PH_RATE_SLOW_MHZ;
    localparam int unsigned LONG_REF_T1_FAST = LONG_REF_MS * 1000 * PH_RATE_FAST_MHZ;
    localparam int unsigned LONG_REF_T1_SLOW = LONG_REF_MS * 1000 * PH_RATE_SLOW_MHZ;
    // go-extension limits in quarter tach pulses
    localparam logic [7:0] GAP_HI_WRITE = 8'h31;
    localparam logic [7:0] GAP_HI_READ = 8'h2a;
    localparam logic [7:0] GAP_HI_BACK = 8'h10;
    localparam logic [7:0] GAP_LO_WRITE = 8'h5a;
    localparam logic [7:0] GAP_LO_READ = 8'h7a;
    localparam logic [7:0] GAP_LO_BACK = 8'h5a;
    localparam logic [7:0] GAP_STOP_DIST = 8'h24;
    // drive counter presets
    localparam logic [7:0] DRV_START_PRESET = 8'h22;
    localparam logic [7:0] DRV_RUN_PRESET = 8'hf8;
    localparam int unsigned DAC_W_FAST = 7;
    localparam int unsigned DAC_W_SLOW = 6;
    localparam int unsigned DAC_W_MAX = 7;
    localparam int unsigned TPC_W = 21;

    typedef enum logic [4:0] {
        CVC_IDLE = 5'h01,
        CVC_START = 5'h02,
        CVC_RUN = 5'h04,
        CVC_EXT = 5'h08,
        CVC_STOP = 5'h10
    } cvc_mode_t;

    // motion tags from the tape control
    typedef struct packed {
        logic move;
        logic write_op;
        logic backward;
        logic high_density;
        logic thread;
    } cvc_tags_t;

    // phase pulse carrier
    typedef struct packed {
        logic [5:0] pulse;
    } cvc_phase_t;
endpackage : cvc_pkg

/* File: src/cvc_phase_gen.sv */
// six-phase clock pulse generator built on a gray-code counter
`timescale 1ns/1ps
`default_nettype none
module cvc_phase_gen #(
    parameter bit FAST = 1'b1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    output var cvc_pkg::cvc_phase_t phases
);
    localparam int unsigned WIDTH = FAST ? cvc_pkg::PH_FAST : cvc_pkg::PH_SLOW;
    localparam int unsigned PERIOD = 1000 / ((FAST ? cvc_pkg::PH_RATE_FAST_MHZ
        : cvc_pkg::PH_RATE_SLOW_MHZ) * 6 * 10);
    localparam int unsigned SLOT = (PERIOD < WIDTH) ? WIDTH : PERIOD;

    typedef struct packed {
        logic [7:0] slot_cnt;
        logic [2:0] gray;
        logic [5:0] pulse;
    } cvc_pg_state_t;

    cvc_pg_state_t st_r, st_nxt;

    function automatic logic [2:0] gray_next(input logic [2:0] g);
        // six-state gray ring, one bit changes per step
        case (g)
            3'h0: gray_next = 3'h1;
            3'h1: gray_next = 3'h3;
            3'h3: gray_next = 3'h7;
            3'h7: gray_next = 3'h6;
            3'h6: gray_next = 3'h4;
            default: gray_next = 3'h0;
        endcase
    endfunction : gray_next

    function automatic logic [5:0] gray_dec(input logic [2:0] g);
        case (g)
            3'h0: gray_dec = 6'h01;
            3'h1: gray_dec = 6'h02;
            3'h3: gray_dec = 6'h04;
            3'h7: gray_dec = 6'h08;
            3'h6: gray_dec = 6'h10;
            3'h4: gray_dec = 6'h20;
            default: gray_dec = 6'h00;
        endcase
    endfunction : gray_dec

    always_comb begin
        st_nxt = st_r;
        if (st_r.slot_cnt == 8'(SLOT - 1)) begin
            st_nxt.slot_cnt = 8'h00;
            st_nxt.gray = gray_next(st_r.gray);
        end else begin
            st_nxt.slot_cnt = st_r.slot_cnt + 8'h01;
        end
        // pulse high for its width at the start of each slot
        st_nxt.pulse = (st_nxt.slot_cnt < 8'(WIDTH)) ? gray_dec(st_nxt.gray) : 6'h00;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign phases.pulse = st_r.pulse;

    a_phase_onehot: assert property (@(posedge sys_clk) disable iff (!resetn)
        $onehot0(st_r.pulse)) else $error("phase pulses overlap");
    a_phase_order: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(st_r.pulse[1]) |-> $past(st_r.gray) == 3'h1 || $past(st_r.pulse[0]))
        else $error("phase one out of order");
endmodule : cvc_phase_gen
`default_nettype wire

/* File: verification/cvc_tach_model.sv */
// quadrature tach model standing in for the capstan and its tachometer
`timescale 1ns/1ps
`default_nettype none
module cvc_tach_model #(
    parameter int unsigned SPACING = 20
) (
    input wire logic sys_clk,
    input wire logic spin,
    input wire logic spin_dir,
    output logic tach_a,
    output logic tach_b,
    output logic [15:0] quarters
);
    logic [1:0] step_r = 2'h0;
    logic [15:0] count_r = 16'h0;
    int unsigned gap_r = 0;
    // gray order moves one line per quarter; counting up lets b lead a
    assign tach_a = step_r[1];
    assign tach_b = step_r[1] ^ step_r[0];
    assign quarters = count_r;
    // wide spacing keeps edges clear of the two-flop synchroniser
    always @(negedge sys_clk) begin
        if (spin) begin
            if (gap_r == SPACING - 1) begin
                gap_r <= 0;
                step_r <= spin_dir ? step_r + 2'h1 : step_r - 2'h1;
                count_r <= count_r + 16'h1;
            end else begin
                gap_r <= gap_r + 1;
            end
        end
    end
endmodule : cvc_tach_model
`default_nettype wire

/* File: verification/cvc_capstan_ctrl_test.sv */
// self-checking bench for the capstan velocity control block
`timescale 1ns/1ps
`default_nettype none
module cvc_capstan_ctrl_test;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic por_active = 1'b1;
    logic reel_rev = 1'b0;
    logic spin = 1'b0;
    logic spin_dir = 1'b1;
    cvc_pkg::cvc_tags_t tags = '0;
    logic tach_a, tach_b, go_ext, forward, period_match, hold_ref_done;
    logic long_ref_pulse, stop_delay1, stop_delay2, at_rest, drive_enable;
    logic [6:0] dac_cmd;
    logic [15:0] quarters;
    int mismatches = 0;
    int n_checks = 0;
    int n_pm = 0;
    int n_sd = 0;
    int n_sd2 = 0;

    // nominal period of one phase-one pulse so matches land inside an 80-cycle tach period
    cvc_capstan_ctrl #(.FAST(1'b1), .HOLD_REF_T1(20), .LONG_REF_T1(50),
        .RUN_PERIOD_T1(1)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .por_active(por_active), .tags(tags),
        .tach_a(tach_a), .tach_b(tach_b), .reel_rev(reel_rev), .go_ext(go_ext),
        .forward(forward), .period_match(period_match), .hold_ref_done(hold_ref_done),
        .long_ref_pulse(long_ref_pulse), .stop_delay1(stop_delay1),
        .stop_delay2(stop_delay2), .at_rest(at_rest), .drive_enable(drive_enable),
        .dac_cmd(dac_cmd));
    cvc_tach_model #(.SPACING(20)) tach (.sys_clk(sys_clk), .spin(spin),
        .spin_dir(spin_dir), .tach_a(tach_a), .tach_b(tach_b), .quarters(quarters));

    always #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        if (period_match === 1'b1) n_pm++;
        if (stop_delay1 === 1'b1) n_sd++;
        if (stop_delay2 === 1'b1) n_sd2++;
    end

    task cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    task t_reset;
        check({go_ext, at_rest, forward, period_match}, 4'h6);
        check(dac_cmd, 7'h00);
        resetn = 1'b1;
        cyc(3);
        check(drive_enable, 1'b0);
        por_active = 1'b0;
        cyc(2);
        check(drive_enable, 1'b1);
    endtask : t_reset

    // position hold: direction decode and quarter tracking at rest
    task t_hold_dir;
        spin_dir = 1'b0;
        spin = 1'b1;
        cyc(200);
        check(forward, 1'b0);
        check(dac_cmd !== 7'h00, 1'b1);
        spin_dir = 1'b1;
        cyc(400);
        check(forward, 1'b1);
        spin = 1'b0;
        cyc(50);
    endtask : t_hold_dir

    // threading: reel revolutions step the gap counter, no motion starts
    task t_thread;
        tags.thread = 1'b1;
        repeat (4) begin
            reel_rev = 1'b1;
            cyc(6);
            reel_rev = 1'b0;
            cyc(6);
        end
        check({go_ext, at_rest}, 2'h1);
        tags = '0;
        cyc(4);
    endtask : t_thread

    task automatic t_go(input logic w, input logic bk, input logic hd, input logic [7:0] lim);
        int k;
        logic [15:0] q0;
        tags = '{move: 1'b1, write_op: w, backward: bk, high_density: hd, thread: 1'b0};
        spin_dir = !bk;
        cyc(3);
        check(go_ext, 1'b1);
        cyc(100);
        if (!bk) check(dac_cmd, 7'h11);
        tags.move = 1'b0;
        q0 = quarters;
        spin = 1'b1;
        k = 0;
        while (go_ext !== 1'b0 && k < 4000) begin cyc(1); k++; end
        check(quarters - q0, {8'h00, lim});
        q0 = quarters;
        k = 0;
        while (at_rest !== 1'b1 && k < 2000) begin cyc(1); k++; end
        spin = 1'b0;
        check(quarters - q0, 16'h0024);
        k = 0;
        // hold reference is 20 phase-one periods of about 48 cycles each
        while (hold_ref_done !== 1'b1 && k < 1200) begin cyc(1); k++; end
        check(k inside {[880:1100]}, 1'b1);
        cyc(20);
    endtask : t_go

    task automatic t_long;
        int k;
        k = 0;
        while (long_ref_pulse !== 1'b1 && k < 3000) begin cyc(1); k++; end
        cyc(1);
        check(long_ref_pulse, 1'b0);
        k = 1;
        while (long_ref_pulse !== 1'b1 && k < 3000) begin cyc(1); k++; end
        check(k inside {[2200:2600]}, 1'b1);
    endtask : t_long

    initial begin
        cyc(4);
        t_reset();
        t_hold_dir();
        t_thread();
        t_go(1'b1, 1'b0, 1'b1, 8'h31);
        t_go(1'b0, 1'b0, 1'b1, 8'h2a);
        t_go(1'b0, 1'b1, 1'b1, 8'h10);
        t_go(1'b1, 1'b0, 1'b0, 8'h5a);
        t_go(1'b0, 1'b0, 1'b0, 8'h7a);
        t_go(1'b0, 1'b1, 1'b0, 8'h5a);
        check(n_pm > 0, 1'b1);
        check(n_sd > 0, 1'b1);
        check(n_sd2 > 0, 1'b1);
        t_long();
        report_and_stop();
    end

    // six stops plus the reference checks take well under 40000 cycles
    initial begin
        #(80000 * 10);
        mismatches++;
        report_and_stop();
    end
endmodule : cvc_capstan_ctrl_test
`default_nettype wire
